// File: core/sbl_bootstrap_led.sv
// bootstrap straps, boot mode, init gating, parallel and serial leds
// Operation
// - cpu boot mode: all ports start disabled
// - eeprom boot: ports forward unless overwritten
// - init done raises ready interrupt
// - register access refused while eeprom runs
// - parallel leds driven low during reset
// - serial led data follows led clock
// - strobe high while serial bit valid
// - port 0 strap: copper low, fiber high
// - port 1 strap: copper low, fiber high
// - port 5 strap high enables digital interface
// - port 4 strap low selects digital interface
// - ports 2 and 3 fixed at auto-negotiation
// - boot select 00 cpu, 10 standalone, 11 eeprom
// - ready low after halt, except standalone
`timescale 1ns/1ps
`include "sbl_regs.svh"
module sbl_bootstrap_led #(
    parameter int NPORTS = 6,
    parameter int NLED   = 5
) (
    input  wire logic               core_clk_i,
    input  wire logic               rst_i,
    input  wire logic [1:0]         boot_select_i,
    input  wire logic               first_port_media_strap_i,
    input  wire logic               second_port_media_strap_i,
    input  wire logic               cpu_port_iface_on_i,
    input  wire logic               fifth_port_iface_off_i,
    input  wire logic               eeprom_halt_i,
    input  wire logic               eeprom_ctrl_wr_i,
    input  wire logic [NPORTS*2-1:0] eeprom_port_state_i,
    input  wire logic [NLED-1:0]    port_status_a_i,
    input  wire logic [NLED-1:0]    port_status_b_i,
    input  wire logic [NLED-1:0]    port_status_c_i,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    output logic [1:0]              s_axi_bresp,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    input  wire logic [7:0]         s_axi_araddr,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic [NPORTS*2-1:0]     port_media_o,
    output logic [NPORTS*2-1:0]     port_state_o,
    output logic                    ports_active_o,
    output logic                    init_done_irq_n_o,
    output logic                    irq_o,
    output logic [NLED-1:0]         port_led_a_n_o,
    output logic [NLED-1:0]         port_led_b_n_o,
    output logic [NLED-1:0]         port_led_c_n_o,
    output logic                    led_shift_clock_o,
    output logic                    led_serial_out_o,
    output logic                    led_serial_strobe_o
);
    // strap capture one cycle after reset release
    logic       strap_taken_r;
    logic       init_done_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_mask_r;
    logic [NLED-1:0] led_en_a_r;
    logic [NLED-1:0] led_en_b_r;
    logic [NLED-1:0] led_en_c_r;

    wire boot_cpu  = (boot_select_i == `SBL_BOOT_CPU);
    wire boot_sa   = (boot_select_i == `SBL_BOOT_STANDALONE);
    wire boot_ee   = (boot_select_i == `SBL_BOOT_EEPROM);
    // standalone ignores the eeprom, so init completes at once
    wire init_fin  = boot_sa || eeprom_halt_i;
    wire busy      = !init_done_r;

    // per-port media decode from straps
    wire [1:0] media_p0 = first_port_media_strap_i ? 2'(sbl_pkg::SBL_MEDIA_FIBER)
                                                   : 2'(sbl_pkg::SBL_MEDIA_COPPER_AN);
    wire [1:0] media_p1 = second_port_media_strap_i ? 2'(sbl_pkg::SBL_MEDIA_FIBER)
                                                    : 2'(sbl_pkg::SBL_MEDIA_COPPER_AN);
    wire [1:0] media_p4 = fifth_port_iface_off_i ? 2'(sbl_pkg::SBL_MEDIA_COPPER_AN)
                                                 : 2'(sbl_pkg::SBL_MEDIA_DIGITAL);
    wire [1:0] media_p5 = cpu_port_iface_on_i ? 2'(sbl_pkg::SBL_MEDIA_DIGITAL)
                                              : 2'(sbl_pkg::SBL_MEDIA_OFF);
    wire [1:0] media_an = 2'(sbl_pkg::SBL_MEDIA_COPPER_AN);
    wire [11:0] media_all = {media_p5, media_p4, media_an, media_an, media_p1, media_p0};

    // boot select is not latched; system keeps it static
    wire [1:0] start_state = boot_cpu ? `SBL_PSTATE_DISABLED : `SBL_PSTATE_FORWARD;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap_taken_r <= 1'b0;
            port_media_o <= '0;
            ports_active_o <= 1'b0;
        end else if (!strap_taken_r) begin
            strap_taken_r <= 1'b1;
            port_media_o <= (NPORTS*2)'(media_all);
        end else begin
            ports_active_o <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            port_state_o <= '0;
        end else if (!strap_taken_r) begin
            port_state_o <= {NPORTS{start_state}};
        end else if (boot_ee && busy && eeprom_ctrl_wr_i) begin
            port_state_o <= eeprom_port_state_i;
        end
    end

    // init done and ready interrupt, active low, never in standalone
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            init_done_r <= 1'b0;
            init_done_irq_n_o <= 1'b1;
        end else begin
            if (strap_taken_r && init_fin) begin
                init_done_r <= 1'b1;
            end
            init_done_irq_n_o <= !(init_done_r && !boot_sa);
        end
    end

    // axi4-lite slave: both write channels taken together, single beat
    wire wr_go  = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    wire rd_go  = s_axi_arvalid && !s_axi_rvalid;
    wire [7:0] wa = s_axi_awaddr;
    wire [7:0] ra = s_axi_araddr;
    wire wa_irqs  = (wa == `SBL_OFS_IRQ_STAT);
    wire wa_mask  = (wa == `SBL_OFS_IRQ_MASK);
    wire wa_led   = (wa == `SBL_OFS_LED_A) || (wa == `SBL_OFS_LED_B)
                    || (wa == `SBL_OFS_LED_C);
    wire wa_ok    = wa_irqs || wa_mask || wa_led || (wa == `SBL_OFS_CTRL)
                    || (wa == `SBL_OFS_STATUS) || (wa == `SBL_OFS_PORT_STATE);
    wire wr_do    = wr_go && !busy && s_axi_wstrb[0];
    wire rd_ok    = (ra == `SBL_OFS_CTRL) || (ra == `SBL_OFS_STATUS)
                    || (ra == `SBL_OFS_IRQ_STAT) || (ra == `SBL_OFS_IRQ_MASK)
                    || (ra == `SBL_OFS_LED_A) || (ra == `SBL_OFS_LED_B)
                    || (ra == `SBL_OFS_LED_C) || (ra == `SBL_OFS_PORT_STATE);
    wire [31:0] rd_val;
    assign rd_val = (ra == `SBL_OFS_CTRL) ? {31'h0, init_done_r}
        : (ra == `SBL_OFS_STATUS) ? {16'h0, port_media_o, ports_active_o, 1'b0,
                                     boot_select_i}
        : (ra == `SBL_OFS_IRQ_STAT) ? {30'h0, irq_stat_r}
        : (ra == `SBL_OFS_IRQ_MASK) ? {30'h0, irq_mask_r}
        : (ra == `SBL_OFS_LED_A) ? {27'h0, led_en_a_r}
        : (ra == `SBL_OFS_LED_B) ? {27'h0, led_en_b_r}
        : (ra == `SBL_OFS_LED_C) ? {27'h0, led_en_c_r}
        : (ra == `SBL_OFS_PORT_STATE) ? {20'h0, port_state_o}
        : 32'h0;
    wire refused_ev = (wr_go || rd_go) && busy;
    // ready event lasts the one cycle before the ready pin falls
    wire ready_ev = init_done_r && init_done_irq_n_o && !boot_sa;
    wire [1:0] ev = {refused_ev, ready_ev};
    wire [1:0] w1c = (wr_do && wa_irqs) ? s_axi_wdata[1:0] : 2'h0;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SBL_RESP_OKAY;
        end else begin
            s_axi_awready <= wr_go;
            s_axi_wready <= wr_go;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (busy || !wa_ok) ? `SBL_RESP_SLVERR : `SBL_RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `SBL_RESP_OKAY;
        end else begin
            s_axi_arready <= rd_go;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= busy ? 32'h0 : rd_val;
                s_axi_rresp <= (busy || !rd_ok) ? `SBL_RESP_SLVERR : `SBL_RESP_OKAY;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // sticky events, set wins over write-one-to-clear
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_stat_r <= 2'h0;
            irq_mask_r <= `SBL_MASK_RST;
            irq_o <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~w1c) | ev;
            if (wr_do && wa_mask) begin
                irq_mask_r <= s_axi_wdata[1:0];
            end
            irq_o <= |(irq_stat_r & irq_mask_r);
        end
    end

    // led enables; out of reset an output lights only when enabled and status active
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            led_en_a_r <= '1;
            led_en_b_r <= '1;
            led_en_c_r <= '1;
        end else if (wr_do) begin
            if (wa == `SBL_OFS_LED_A) led_en_a_r <= s_axi_wdata[NLED-1:0];
            if (wa == `SBL_OFS_LED_B) led_en_b_r <= s_axi_wdata[NLED-1:0];
            if (wa == `SBL_OFS_LED_C) led_en_c_r <= s_axi_wdata[NLED-1:0];
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            port_led_a_n_o <= '0;
            port_led_b_n_o <= '0;
            port_led_c_n_o <= '0;
        end else begin
            port_led_a_n_o <= ~(led_en_a_r & port_status_a_i);
            port_led_b_n_o <= ~(led_en_b_r & port_status_b_i);
            port_led_c_n_o <= ~(led_en_c_r & port_status_c_i);
        end
    end

    // serial stream carries all three status sets, port 4 first
    sbl_led_serializer #(
        .NBITS (3 * NLED)
    ) u_ser (
        .core_clk_i          (core_clk_i),
        .rst_i               (rst_i),
        .bits_i              ({port_status_c_i, port_status_b_i, port_status_a_i}),
        .led_shift_clock_o   (led_shift_clock_o),
        .led_serial_out_o    (led_serial_out_o),
        .led_serial_strobe_o (led_serial_strobe_o)
    );

    chk_cpu_ports_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $rose(strap_taken_r) && boot_cpu |-> port_state_o == '0)
        else $error("cpu boot did not start ports disabled");
    chk_ee_ports_fwd: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $rose(strap_taken_r) && boot_ee |-> port_state_o == {NPORTS{`SBL_PSTATE_FORWARD}})
        else $error("eeprom boot did not start ports forwarding");
    chk_ee_overwrite: assert property (@(posedge core_clk_i) disable iff (rst_i)
        strap_taken_r && boot_ee && busy && eeprom_ctrl_wr_i
        |=> port_state_o == $past(eeprom_port_state_i))
        else $error("eeprom port state write not applied");
    chk_ready_irq: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $rose(init_done_r) && !boot_sa |=> !init_done_irq_n_o)
        else $error("ready interrupt missing after init");
    chk_ready_stat: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $rose(init_done_r) && !boot_sa |=> irq_stat_r[`SBL_IRQ_READY])
        else $error("ready status bit not set after init");
    // irq pin lags the unmasked status by the one output flop
    chk_irq_level: assert property (@(posedge core_clk_i) disable iff (rst_i)
        |(irq_stat_r & irq_mask_r) |=> irq_o)
        else $error("irq low while unmasked status set");
    chk_standalone_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i)
        boot_sa |=> init_done_irq_n_o)
        else $error("ready interrupt asserted in standalone");
    chk_standalone_init: assert property (@(posedge core_clk_i) disable iff (rst_i)
        strap_taken_r && boot_sa |=> init_done_r)
        else $error("standalone did not finish init at once");
    chk_busy_refuse: assert property (@(posedge core_clk_i) disable iff (rst_i)
        wr_go && busy |=> s_axi_bvalid && s_axi_bresp == `SBL_RESP_SLVERR)
        else $error("write accepted while eeprom busy");
    // refused writes must leave the mask and led enable registers untouched
    chk_busy_no_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
        wr_go && busy |=> $stable(irq_mask_r) && $stable(led_en_a_r)
            && $stable(led_en_b_r) && $stable(led_en_c_r))
        else $error("register changed by a refused write");
    chk_busy_rd_refuse: assert property (@(posedge core_clk_i) disable iff (rst_i)
        rd_go && busy |=> s_axi_rvalid && s_axi_rresp == `SBL_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("read answered while eeprom busy");
    chk_media_p0: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $rose(strap_taken_r) |-> port_media_o[1:0] == $past(media_p0))
        else $error("port 0 media not taken from strap");
    chk_media_p1: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $rose(strap_taken_r) |-> port_media_o[3:2] == $past(media_p1))
        else $error("port 1 media not taken from strap");
    chk_media_an: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $rose(strap_taken_r) |-> port_media_o[7:4] == {2{2'(sbl_pkg::SBL_MEDIA_COPPER_AN)}})
        else $error("ports 2 and 3 not in auto-negotiation");
    chk_media_p4: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $rose(strap_taken_r) |-> port_media_o[9:8] == $past(media_p4))
        else $error("port 4 mode not taken from strap");
    chk_media_p5: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $rose(strap_taken_r) |-> port_media_o[11:10] == $past(media_p5))
        else $error("port 5 mode not taken from strap");
    chk_active_after: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ports_active_o |-> strap_taken_r)
        else $error("port active before straps applied");
endmodule

// File: core/sbl_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef SBL_REGS_SVH
`define SBL_REGS_SVH

`define SBL_ADDR_W         8
`define SBL_OFS_CTRL       8'h00
`define SBL_OFS_STATUS     8'h04
`define SBL_OFS_IRQ_STAT   8'h08
`define SBL_OFS_IRQ_MASK   8'h0C
`define SBL_OFS_LED_A      8'h10
`define SBL_OFS_LED_B      8'h14
`define SBL_OFS_LED_C      8'h18
`define SBL_OFS_PORT_STATE 8'h1C

`define SBL_CTRL_INIT_DONE 0
`define SBL_IRQ_READY      0
`define SBL_IRQ_REFUSED    1
`define SBL_IRQ_W          2
`define SBL_MASK_RST       2'h3

`define SBL_BOOT_CPU       2'h0
`define SBL_BOOT_STANDALONE 2'h2
`define SBL_BOOT_EEPROM    2'h3

`define SBL_PSTATE_DISABLED 2'h0
`define SBL_PSTATE_FORWARD  2'h3

`define SBL_CLK_MHZ        200
`define SBL_LED_CLK_NS     80
`define SBL_LED_HALF_CYC   ((`SBL_LED_CLK_NS * `SBL_CLK_MHZ) / 2000)

`define SBL_RESP_OKAY      2'h0
`define SBL_RESP_SLVERR    2'h2

`endif

// File: core/sbl_pkg.sv
// types for the bootstrap and led block
package sbl_pkg;
    typedef enum logic [1:0] {
        SBL_MEDIA_COPPER_AN,
        SBL_MEDIA_FIBER,
        SBL_MEDIA_DIGITAL,
        SBL_MEDIA_OFF
    } sbl_media_e;
    typedef enum logic [1:0] {
        SBL_LS_IDLE,
        SBL_LS_SHIFT,
        SBL_LS_GAP
    } sbl_led_state_e;
endpackage

// File: core/sbl_led_serializer.sv
// serial led shifter: drives shift clock, data and strobe
`timescale 1ns/1ps
`include "sbl_regs.svh"
module sbl_led_serializer #(
    parameter int NBITS = 15
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_i,
    input  wire logic [NBITS-1:0] bits_i,
    output logic                  led_shift_clock_o,
    output logic                  led_serial_out_o,
    output logic                  led_serial_strobe_o
);
    localparam int HALF = (`SBL_LED_HALF_CYC < 1) ? 1 : `SBL_LED_HALF_CYC;
    localparam int CW = $clog2(HALF + 1);
    localparam int BW = $clog2(NBITS + 1);

    sbl_pkg::sbl_led_state_e st_r;
    logic [CW-1:0]    div_r;
    logic [BW-1:0]    idx_r;
    logic [NBITS-1:0] shreg_r;
    wire              tick = (div_r == CW'(HALF - 1));
    wire              fall = tick && led_shift_clock_o;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_r <= '0;
            led_shift_clock_o <= 1'b0;
        end else begin
            div_r <= tick ? '0 : div_r + CW'(1);
            if (tick) begin
                led_shift_clock_o <= ~led_shift_clock_o;
            end
        end
    end

    // data and strobe change on the falling edge, stable at the rising one
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= sbl_pkg::SBL_LS_IDLE;
            idx_r <= '0;
            shreg_r <= '0;
            led_serial_out_o <= 1'b0;
            led_serial_strobe_o <= 1'b0;
        end else if (fall) begin
            case (st_r)
                sbl_pkg::SBL_LS_IDLE: begin
                    shreg_r <= bits_i;
                    idx_r <= '0;
                    st_r <= sbl_pkg::SBL_LS_SHIFT;
                end
                sbl_pkg::SBL_LS_SHIFT: begin
                    led_serial_out_o <= shreg_r[NBITS-1];
                    led_serial_strobe_o <= 1'b1;
                    shreg_r <= {shreg_r[NBITS-2:0], 1'b0};
                    idx_r <= idx_r + BW'(1);
                    if (idx_r == BW'(NBITS - 1)) begin
                        st_r <= sbl_pkg::SBL_LS_GAP;
                    end
                end
                default: begin
                    led_serial_strobe_o <= 1'b0;
                    led_serial_out_o <= 1'b0;
                    st_r <= sbl_pkg::SBL_LS_IDLE;
                end
            endcase
        end
    end

    // strobe only ever moves together with the falling shift clock
    chk_strobe_on_fall: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $changed(led_serial_strobe_o) |-> $fell(led_shift_clock_o))
        else $error("strobe changed off the falling led clock");
    chk_data_on_fall: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $changed(led_serial_out_o) |-> $fell(led_shift_clock_o))
        else $error("serial data changed off the falling led clock");
endmodule

// File: tb/sbl_eeprom_model.sv
// behavioural serial config memory: optional port-state write, then halt
`timescale 1ns/1ps
module sbl_eeprom_model (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  delay_i,
    input  wire logic        do_wr_i,
    input  wire logic [11:0] wr_state_i,
    output logic             halt_o,
    output logic             ctrl_wr_o,
    output logic [11:0]      state_o
);
    logic [7:0] cnt_r;
    logic       wr_now;

    assign wr_now = do_wr_i && (cnt_r == 8'h08);

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r     <= 8'h00;
            halt_o    <= 1'b0;
            ctrl_wr_o <= 1'b0;
            state_o   <= 12'hFFF;
        end else begin
            cnt_r     <= halt_o ? cnt_r : cnt_r + 8'h01;
            halt_o    <= halt_o || (cnt_r >= delay_i);
            ctrl_wr_o <= wr_now;
            // data only means something with the strobe, so it toggles otherwise
            state_o   <= wr_now ? wr_state_i : ~state_o;
        end
    end
endmodule

// File: tb/tb_sbl_bootstrap_led.sv
// self-checking bench for the bootstrap and led block
`timescale 1ns/1ps
`include "sbl_regs.svh"
module tb_sbl_bootstrap_led;
    localparam int CEIL = 20000;
    logic        clk, rst, p0s, p1s, p5on, p4off, halt, cwr, dow;
    logic [1:0]  bsel, bresp, rresp, rsp;
    logic [11:0] est, wst, media, pstate;
    logic [7:0]  dly, awa, ara;
    logic [4:0]  sa, sb, sc, la, lb, lc;
    logic        awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
    logic        act, irqn, irq, lclk, lser, lstb;
    logic [31:0] wd, rd, dat;
    logic [14:0] frm;
    int          err_total, n_compared, cyc, i;

    sbl_bootstrap_led uut (
        .core_clk_i(clk), .rst_i(rst), .boot_select_i(bsel),
        .first_port_media_strap_i(p0s), .second_port_media_strap_i(p1s),
        .cpu_port_iface_on_i(p5on), .fifth_port_iface_off_i(p4off),
        .eeprom_halt_i(halt), .eeprom_ctrl_wr_i(cwr), .eeprom_port_state_i(est),
        .port_status_a_i(sa), .port_status_b_i(sb), .port_status_c_i(sc),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
        .port_media_o(media), .port_state_o(pstate), .ports_active_o(act),
        .init_done_irq_n_o(irqn), .irq_o(irq),
        .port_led_a_n_o(la), .port_led_b_n_o(lb), .port_led_c_n_o(lc),
        .led_shift_clock_o(lclk), .led_serial_out_o(lser), .led_serial_strobe_o(lstb)
    );

    sbl_eeprom_model eep (
        .core_clk_i(clk), .rst_i(rst), .delay_i(dly), .do_wr_i(dow),
        .wr_state_i(wst), .halt_o(halt), .ctrl_wr_o(cwr), .state_o(est)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == CEIL) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // address and data offered together, each dropped once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awa <= a;
        wd  <= d;
        awv <= 1'b1;
        wv  <= 1'b1;
        br  <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (bv !== 1'b1);
        r = bresp;
        br <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr  <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        d = rd;
        r = rresp;
        rr <= 1'b0;
    endtask

    // straps and boot code only change while reset is held
    task automatic boot(input logic [1:0] m, input logic [3:0] st);
        @(posedge clk);
        rst <= 1'b1;
        bsel <= m;
        {p0s, p1s, p5on, p4off} <= st;
        repeat (4) @(posedge clk);
        chk({la, lb, lc}, 32'h0);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic wait_ready();
        for (i = 0; i < 300 && irqn !== 1'b0; i++) @(posedge clk);
    endtask

    // skip the frame in flight, then collect one whole frame
    task automatic grab(output logic [14:0] f);
        int k;
        @(negedge lstb);
        k = 0;
        while (k < 15) begin
            @(posedge lclk);
            if (lstb === 1'b1) begin
                f = {f[13:0], lser};
                k++;
            end
        end
    endtask

    initial begin
        {rst, bsel, p0s, p1s, p5on, p4off, dow, wst} = {1'b1, 19'h0};
        {awv, wv, br, arv, rr, awa, ara, wd} = '0;
        {sa, sb, sc} = {5'h15, 5'h0C, 5'h13};
        {err_total, n_compared, cyc} = '0;
        dly = 8'd40;
        boot(2'h0, 4'b1010);
        chk(media, 32'hA01);
        chk(pstate, 32'h0);
        chk(act, 32'h1);
        chk(irqn, 32'h1);
        axr(`SBL_OFS_CTRL, dat, rsp);
        chk(rsp, `SBL_RESP_SLVERR);
        chk(dat, 32'h0);
        wait_ready();
        chk(irqn, 32'h0);
        axr(`SBL_OFS_CTRL, dat, rsp);
        chk({rsp, dat[0]}, {`SBL_RESP_OKAY, 1'b1});
        axr(`SBL_OFS_IRQ_STAT, dat, rsp);
        chk(dat, 32'h3);
        chk(irq, 32'h1);
        axw(`SBL_OFS_IRQ_MASK, 32'h0, rsp);
        repeat (3) @(posedge clk);
        chk(irq, 32'h0);
        axw(`SBL_OFS_IRQ_MASK, 32'h3, rsp);
        repeat (3) @(posedge clk);
        chk(irq, 32'h1);
        axw(`SBL_OFS_IRQ_STAT, 32'h3, rsp);
        repeat (3) @(posedge clk);
        chk(irq, 32'h0);
        axr(8'h40, dat, rsp);
        chk(rsp, `SBL_RESP_SLVERR);
        chk({la, lb, lc} ^ {sa, sb, sc}, 32'h7FFF);
        axw(`SBL_OFS_LED_A, 32'h0, rsp);
        repeat (3) @(posedge clk);
        chk(la, 32'h1F);
        grab(frm);
        chk(frm, {sc, sb, sa});
        $display("test cpu boot done");
        dly <= 8'd60;
        dow <= 1'b1;
        wst <= 12'h5A6;
        boot(2'h3, 4'b0101);
        chk(media, 32'hC04);
        chk(pstate, 32'hFFF);
        axw(`SBL_OFS_LED_B, 32'h0, rsp);
        chk(rsp, `SBL_RESP_SLVERR);
        repeat (10) @(posedge clk);
        chk(pstate, 32'h5A6);
        chk(lb ^ sb, 32'h1F);
        wait_ready();
        chk(irqn, 32'h0);
        $display("test eeprom boot done");
        dly <= 8'd200;
        dow <= 1'b0;
        boot(2'h2, 4'b0000);
        chk(media, 32'hE00);
        axr(`SBL_OFS_CTRL, dat, rsp);
        chk({rsp, dat[0]}, {`SBL_RESP_OKAY, 1'b1});
        repeat (30) @(posedge clk);
        chk(irqn, 32'h1);
        $display("test standalone boot done");
        give_verdict();
    end
endmodule
